/* File: bench/acrs_conv_model.sv */
// Converter sequencer model that issues start and completion events to the block.
`timescale 1ns/100ps

module acrs_conv_model
  import acrs_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Commands from the bench
  input wire logic go_in,
  input wire logic prio_in,
  input wire logic start_in,
  input wire logic scan_end_in,
  input wire logic [3:0] channel_in,
  input wire logic [15:0] data_in,
  input wire logic [7:0] lat_in,
  // Events towards the block
  output acrs_evt_s evt_out,
  output logic busy_out
);
  logic [7:0] cnt_reg;
  acrs_evt_s hold_reg;

  assign busy_out = (cnt_reg != 8'h00);

  // Outside a completion the channel and data qualifiers keep toggling, so the block cannot
  // lean on stale channel or data values.
  always @(posedge clk_in) begin
    if (srst_in) begin
      evt_out <= '0;
      cnt_reg <= 8'h00;
      hold_reg <= '0;
    end else begin
      evt_out.start_normal <= go_in & start_in & ~prio_in;
      evt_out.start_prio <= go_in & start_in & prio_in;
      evt_out.done <= (cnt_reg == 8'h01);
      evt_out.prio <= hold_reg.prio;
      evt_out.scan_end <= (cnt_reg == 8'h01) & hold_reg.scan_end;
      evt_out.channel <= (cnt_reg == 8'h01) ? hold_reg.channel : ~evt_out.channel;
      evt_out.data <= (cnt_reg == 8'h01) ? hold_reg.data : ~evt_out.data;
      if (go_in) begin
        hold_reg.prio <= prio_in;
        hold_reg.scan_end <= scan_end_in;
        hold_reg.channel <= channel_in;
        hold_reg.data <= data_in;
        cnt_reg <= lat_in;
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule : acrs_conv_model

/* File: bench/acrs_top_tb.sv */
// Self-checking testbench of the completion flags and result storage block.
`timescale 1ns/100ps

module acrs_top_tb
  import acrs_pkg::*;
;
  localparam int RW = 10;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  acrs_avl_req_s req = '0;
  logic [31:0] rdata;
  logic wait_req;
  acrs_evt_s evt;
  logic nirq, pirq, mbusy, nirq_d, pirq_d;
  logic go = 1'b0, prio = 1'b0, strt = 1'b0, send = 1'b0;
  logic [3:0] ch = 4'h0;
  logic [15:0] dat = 16'h0000;
  logic [7:0] lat = 8'h01;
  logic [15:0] d [8], sv [8];
  int failures = 0, n_compared = 0, n_nirq = 0, n_pirq = 0;

  initial forever #2 clk_in = ~clk_in;

  acrs_top #(.RES_W(RW)) dut (.clk_in(clk_in), .srst_in(srst_in), .avs_req_in(req),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req), .conv_evt_in(evt),
    .normal_done_irq_out(nirq), .priority_done_irq_out(pirq));

  acrs_conv_model conv_model (.clk_in(clk_in), .srst_in(srst_in), .go_in(go),
    .prio_in(prio), .start_in(strt), .scan_end_in(send), .channel_in(ch), .data_in(dat),
    .lat_in(lat), .evt_out(evt), .busy_out(mbusy));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic stop_test();
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Irq pulses are counted here; a pulse two cycles wide is a mismatch.
  always @(posedge clk_in) begin
    nirq_d <= nirq;
    pirq_d <= pirq;
    if (nirq === 1'b1) n_nirq++;
    if (pirq === 1'b1) n_pirq++;
    if (!srst_in) check("irq width", 32'h0, {30'h0, nirq & nirq_d, pirq & pirq_d});
  end

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    int i;
    @(posedge clk_in);
    req.read <= ~wr;
    req.write <= wr;
    req.address <= a;
    req.writedata <= wd;
    req.byteenable <= 4'hF;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_in);
      if (wait_req === 1'b0) break;
    end
    if (i == 20) begin
      failures++;
      stop_test();
    end
    rd = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] r;
    xfer(1'b1, a, wd, r);
  endtask : wr

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    check(what, exp, r);
  endtask : rchk

  task automatic conv(input logic p, input logic s, input logic [3:0] c,
                      input logic [15:0] dv, input logic e);
    int i;
    @(posedge clk_in);
    go <= 1'b1;
    prio <= p;
    strt <= s;
    ch <= c;
    dat <= dv;
    send <= e;
    @(posedge clk_in);
    go <= 1'b0;
    for (i = 0; i < 300; i++) begin
      @(posedge clk_in);
      if (mbusy === 1'b0) break;
    end
    if (i == 300) begin
      failures++;
      stop_test();
    end
    repeat (2) @(posedge clk_in);
  endtask : conv

  function automatic logic [31:0] res(input logic [15:0] dv, input logic o);
    res = {1'b1, o, 20'h0_0000, dv[RW-1:0]};
  endfunction : res

  function automatic logic [31:0] mword(input logic e, input logic b, input int itm,
                                        input logic s, input logic r);
    mword = {24'h00_0000, e, b, 2'h0, 2'(itm), s, r};
  endfunction : mword

  function automatic int slot_of(input int c);
    slot_of = (c >= 8 && c <= 11) ? c - 8 : ((c >= 4 && c <= 7) ? c : -1);
  endfunction : slot_of

  // Expected slot contents after eight fixed-repeat conversions.
  function automatic logic [31:0] exp_rep(input int m, input int k);
    if (m == 2) exp_rep = res(d[k], 1'b0);
    else if (m == 1) exp_rep = (k < 4) ? res(d[k + 4], 1'b1) : {22'h0, sv[k][RW-1:0]};
    else exp_rep = (k == 0) ? res(d[7], 1'b1) : {22'h0, sv[k][RW-1:0]};
  endfunction : exp_rep

  function automatic logic [7:0] sa(input int k);
    sa = 8'(8'h10 + 4 * k);
  endfunction : sa

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    int k, m, c;
    logic [31:0] r;
    void'($urandom(32'hA966_DFC6));
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    rchk("mode reset", 8'h00, 32'h0);
    rchk("pmode reset", 8'h04, 32'h0);
    rchk("prio result reset", 8'h30, 32'h0);
    rchk("unmapped", 8'h3C, 32'h0);
    d[0] = 16'($urandom);
    lat <= 8'h28;
    fork
      conv(1'b0, 1'b1, 4'h8, d[0], 1'b0);
      begin repeat (4) @(posedge clk_in); rchk("busy on", 8'h00, 32'h40); end
    join
    rchk("single done", 8'h00, 32'h80);
    rchk("end cleared", 8'h00, 32'h0);
    check("single irqs", 32'h1, 32'(n_nirq));
    rchk("slot0 valid", sa(0), res(d[0], 1'b0));
    rchk("slot0 read clear", sa(0), {22'h0, d[0][RW-1:0]});
    for (c = 0; c < 16; c++) begin
      lat <= 8'($urandom_range(1, 4));
      d[0] = 16'($urandom);
      conv(1'b0, 1'b1, 4'(c), d[0], 1'b0);
      if (slot_of(c) >= 0) begin
        rchk("channel slot", sa(slot_of(c)), res(d[0], 1'b0));
        sv[slot_of(c)] = d[0];
      end
    end
    rchk("high channels", sa(0), {22'h0, sv[0][RW-1:0]});
    check("map irqs", 32'd17, 32'(n_nirq));
    d[0] = 16'($urandom);
    d[1] = 16'($urandom);
    conv(1'b0, 1'b1, 4'h9, d[0], 1'b0);
    conv(1'b0, 1'b1, 4'h9, d[1], 1'b0);
    rchk("overrun", sa(1), res(d[1], 1'b1));
    sv[1] = d[1];
    rchk("mode after map", 8'h00, 32'h80);
    lat <= 8'h01;
    for (m = 0; m < 4; m++) begin
      for (k = 0; k < 8; k++) xfer(1'b0, sa(k), 32'h0, r);
      wr(8'h00, mword(1'b0, 1'b0, m, 1'b0, 1'b1));
      c = n_nirq;
      for (k = 0; k < 8; k++) begin
        d[k] = 16'($urandom);
        conv(1'b0, k == 0, 4'h5, d[k], 1'b0);
      end
      check("repeat irqs", (m == 3) ? 0 : 8 / ((m == 0) ? 1 : 4 * m), 32'(n_nirq - c));
      rchk("repeat mode", 8'h00, mword(m != 3, 1'b1, m, 1'b0, 1'b1));
      for (k = 0; k < 8; k++) begin
        rchk("repeat slot", sa(k), exp_rep(m, k));
        sv[k] = 16'(exp_rep(m, k));
      end
    end
    wr(8'h00, 32'h2);
    c = n_nirq;
    for (k = 0; k < 3; k++) d[k] = 16'($urandom);
    conv(1'b0, 1'b1, 4'h4, d[0], 1'b0);
    conv(1'b0, 1'b0, 4'h5, d[1], 1'b0);
    check("scan mid irqs", 32'h0, 32'(n_nirq - c));
    conv(1'b0, 1'b0, 4'h6, d[2], 1'b1);
    check("scan irqs", 32'h1, 32'(n_nirq - c));
    rchk("scan mode", 8'h00, 32'h82);
    for (k = 0; k < 3; k++) rchk("scan slot", sa(k + 4), res(d[k], 1'b0));
    wr(8'h00, 32'h3);
    c = n_nirq;
    for (k = 0; k < 4; k++) begin
      d[k] = 16'($urandom);
      conv(1'b0, k == 0, 4'(8 + k % 2), d[k], k % 2 == 1);
    end
    check("scan repeat irqs", 32'h2, 32'(n_nirq - c));
    rchk("scan repeat mode", 8'h00, 32'hC3);
    rchk("scan repeat slot", sa(0), res(d[2], 1'b1));
    c = n_nirq;
    d[0] = 16'($urandom);
    lat <= 8'h28;
    fork
      conv(1'b1, 1'b1, 4'hB, d[0], 1'b0);
      begin repeat (4) @(posedge clk_in); rchk("pbusy on", 8'h04, 32'h40); end
    join
    rchk("prio done", 8'h04, 32'h80);
    rchk("pend cleared", 8'h04, 32'h0);
    check("prio irqs", 32'h1, 32'(n_pirq));
    check("normal irqs kept", 32'(c), 32'(n_nirq));
    rchk("prio result", 8'h30, res(d[0], 1'b0));
    rchk("slot3 untouched", sa(3), {22'h0, sv[3][RW-1:0]});
    stop_test();
  end
endmodule : acrs_top_tb

/* File: hw/acrs_avl_slave.sv */
// Avalon-MM handshake: one wait cycle, then the transfer completes.
`timescale 1ns/100ps

module acrs_avl_slave
  import acrs_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Request seen
  input wire logic req_in,
  // Handshake
  output logic waitrequest_out,
  output logic capture_out,
  output logic take_out
);

  typedef struct packed {
    acrs_avl_e st;
    logic wait_rq;
  } acrs_slv_s;

  acrs_slv_s s_reg;
  acrs_slv_s s_next;

  always_comb begin
    s_next = s_reg;
    unique case (s_reg.st)
      ACRS_AVL_IDLE: begin
        if (req_in) begin
          s_next.st = ACRS_AVL_ACK;
          s_next.wait_rq = 1'b0;
        end
      end
      ACRS_AVL_ACK: begin
        s_next.st = ACRS_AVL_IDLE;
        s_next.wait_rq = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_reg <= '{st: ACRS_AVL_IDLE, wait_rq: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  assign waitrequest_out = s_reg.wait_rq;
  assign capture_out = req_in && (s_reg.st == ACRS_AVL_IDLE);
  assign take_out = s_reg.st == ACRS_AVL_ACK;

  wait_one_cycle_a: assert property (@(posedge clk_in) disable iff (srst_in)
    !waitrequest_out |=> waitrequest_out)
    else $error("waitrequest stayed low two cycles");

endmodule : acrs_avl_slave

/* File: hw/acrs_params.svh */
// Register offsets, field positions and reset values of the result storage block.
`ifndef ACRS_PARAMS_SVH
`define ACRS_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define ACRS_AW 8
`define ACRS_OFF_NMODE 8'h00
`define ACRS_OFF_PMODE 8'h04
`define ACRS_OFF_SLOT0 8'h10
`define ACRS_SLOT_STRIDE 8'h04
`define ACRS_OFF_PRES 8'h30

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define ACRS_REPEAT_BIT 0
`define ACRS_SCAN_BIT 1
`define ACRS_ITM_LSB 2
`define ACRS_BUSY_BIT 6
`define ACRS_END_BIT 7
`define ACRS_OVR_BIT 30
`define ACRS_RDY_BIT 31
`define ACRS_ITM_ONE 2'h0
`define ACRS_ITM_FOUR 2'h1
`define ACRS_ITM_EIGHT 2'h2
`define ACRS_ITM_RSVD 2'h3
`define ACRS_LAST_FOUR 3'h3
`define ACRS_LAST_EIGHT 3'h7
`define ACRS_SLOTS 8
`define ACRS_DATA_W 16
`define ACRS_RES_W 10
`define ACRS_RST_WORD 32'h0000_0000

`endif

/* File: hw/acrs_pkg.sv */
// Types shared by the result storage block and its helpers.
`include "acrs_params.svh"

package acrs_pkg;

  // One converter event per cycle, from the sequencer on the same clock.
  typedef struct packed {
    logic start_normal;
    logic start_prio;
    logic done;
    logic prio;
    logic [3:0] channel;
    logic [`ACRS_DATA_W-1:0] data;
    logic scan_end;
  } acrs_evt_s;

  typedef struct packed {
    logic read;
    logic write;
    logic [`ACRS_AW-1:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } acrs_avl_req_s;

  typedef enum logic {
    ACRS_AVL_IDLE = 1'b0,
    ACRS_AVL_ACK = 1'b1
  } acrs_avl_e;

  typedef logic [2:0] acrs_slot_t;

  // Inputs 8..11 own slots 0..3, inputs 4..7 own slots 4..7; others store nowhere.
  function automatic logic [3:0] acrs_slot_of(input logic [3:0] ch);
    acrs_slot_of = {ch[3] ^ ch[2], ch[2] & ~ch[3], ch[1:0]};
  endfunction : acrs_slot_of

endpackage : acrs_pkg

/* File: hw/acrs_seq_ctr.sv */
// Sequential slot pointer for fixed-channel repeat conversion.
`timescale 1ns/100ps

module acrs_seq_ctr
  import acrs_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Control
  input wire logic clear_in,
  input wire logic step_in,
  input wire logic [1:0] itm_in,
  // Pointer
  output acrs_slot_t slot_out,
  output logic wrap_out
);

  typedef struct packed {
    acrs_slot_t ptr;
  } acrs_ctr_s;

  acrs_ctr_s s_reg;
  acrs_ctr_s s_next;
  acrs_slot_t last;

  always_comb begin
    last = (itm_in == `ACRS_ITM_FOUR) ? `ACRS_LAST_FOUR : `ACRS_LAST_EIGHT;
    slot_out = (itm_in == `ACRS_ITM_ONE || itm_in == `ACRS_ITM_RSVD) ? '0 : s_reg.ptr;
    // The reserved interval never completes a group.
    wrap_out = (itm_in == `ACRS_ITM_ONE) ||
               ((itm_in != `ACRS_ITM_RSVD) && (s_reg.ptr == last));
    s_next = s_reg;
    if (clear_in) begin
      s_next.ptr = '0;
    end else if (step_in) begin
      s_next.ptr = wrap_out ? '0 : acrs_slot_t'(s_reg.ptr + 3'h1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : acrs_seq_ctr

/* File: hw/acrs_top.sv */
// Completion flags, interrupts and result storage of the converter controller.
// Function
// - Normal completion sets the end flag so software may poll it.
// - Each result holds overrun and ready bits; ready 1 and overrun 0 means valid.
// - Fixed single: interrupt and end flag after conversion, busy cleared.
// - Fixed repeat, interval 00: interrupt and end flag every conversion.
// - Fixed repeat, interval 01: interrupt and end flag every four conversions.
// - Fixed repeat, interval 10: interrupt and end flag every eight conversions.
// - Both repeat modes keep busy at 1 after each completion interrupt.
// - Scan single: interrupt and end flag after whole scan, busy cleared.
// - Scan repeat: interrupt and end flag after each full scan pass.
// - Priority completion raises its interrupt, sets its end flag, clears busy.
// - Both end flags clear when software reads them.
// - Outside fixed repeat, inputs 8-11 go to slots 0-3, 4-7 to 4-7.
// - Fixed repeat with per-conversion interrupt always stores into slot 0.
// - Fixed repeat by four or eight fills slots in order, then wraps.
// - Priority results go to their own separate result register.
// - Busy flags rise when their conversion begins, unless a completion that clears busy lands in the same cycle.
`timescale 1ns/100ps

module acrs_top
  import acrs_pkg::*;
#(
  parameter int RES_W = `ACRS_RES_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Register bus
  input acrs_avl_req_s avs_req_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Converter events
  input acrs_evt_s conv_evt_in,
  // Completion interrupts
  output logic normal_done_irq_out,
  output logic priority_done_irq_out
);

  generate
    if (RES_W < 1 || RES_W > `ACRS_DATA_W) begin : g_bad_width
      $error("RES_W must lie between 1 and the converter data width");
    end
  endgenerate

  typedef struct packed {
    logic repeat_on;
    logic scan_on;
    logic [1:0] itm;
    logic nbusy;
    logic nend;
    logic pbusy;
    logic pend;
    logic nirq;
    logic pirq;
    logic [`ACRS_SLOTS-1:0] rdy;
    logic [`ACRS_SLOTS-1:0] ovr;
    logic [`ACRS_SLOTS-1:0][RES_W-1:0] val;
    logic prdy;
    logic povr;
    logic [RES_W-1:0] pval;
    logic [31:0] rdata;
  } acrs_state_s;

  acrs_state_s s_reg;
  acrs_state_s s_next;

  logic capture;
  logic take;
  logic rd_take;
  logic fix_rep;
  logic seq_clear;
  logic seq_step;
  acrs_slot_t seq_slot;
  logic seq_wrap;
  logic [3:0] map;
  acrs_slot_t idx;
  logic store;
  logic hit;
  logic [31:0] word;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  acrs_avl_slave u_slave (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .req_in(avs_req_in.read || avs_req_in.write),
    .waitrequest_out(avs_waitrequest_out),
    .capture_out(capture),
    .take_out(take)
  );

  assign fix_rep = s_reg.repeat_on && !s_reg.scan_on;
  assign seq_step = conv_evt_in.done && !conv_evt_in.prio && fix_rep;
  // A mode write or a fresh start restarts the slot sequence at slot 0.
  assign seq_clear = !fix_rep || conv_evt_in.start_normal ||
                     (take && avs_req_in.write && avs_req_in.address == `ACRS_OFF_NMODE);

  acrs_seq_ctr u_seq (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .clear_in(seq_clear),
    .step_in(seq_step),
    .itm_in(s_reg.itm),
    .slot_out(seq_slot),
    .wrap_out(seq_wrap)
  );

  assign rd_take = take && avs_req_in.read;
  assign map = acrs_slot_of(conv_evt_in.channel);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // One compare serves both the read mux and the clear-on-read path, so the
  // two can never disagree about which slot an address selects.
  function automatic logic is_slot(input logic [`ACRS_AW-1:0] addr, input int i);
    is_slot = (addr == `ACRS_AW'(`ACRS_OFF_SLOT0 + i * `ACRS_SLOT_STRIDE));
  endfunction : is_slot

  // ----------------------------------------------------------------------
  // Read word decode
  // ----------------------------------------------------------------------
  always_comb begin
    word = `ACRS_RST_WORD;
    if (avs_req_in.address == `ACRS_OFF_NMODE) begin
      word[`ACRS_REPEAT_BIT] = s_reg.repeat_on;
      word[`ACRS_SCAN_BIT] = s_reg.scan_on;
      word[`ACRS_ITM_LSB +: 2] = s_reg.itm;
      word[`ACRS_BUSY_BIT] = s_reg.nbusy;
      word[`ACRS_END_BIT] = s_reg.nend;
    end
    if (avs_req_in.address == `ACRS_OFF_PMODE) begin
      word[`ACRS_BUSY_BIT] = s_reg.pbusy;
      word[`ACRS_END_BIT] = s_reg.pend;
    end
    for (int i = 0; i < `ACRS_SLOTS; i++) begin
      if (is_slot(avs_req_in.address, i)) begin
        word[`ACRS_RDY_BIT] = s_reg.rdy[i];
        word[`ACRS_OVR_BIT] = s_reg.ovr[i];
        word[RES_W-1:0] = s_reg.val[i];
      end
    end
    if (avs_req_in.address == `ACRS_OFF_PRES) begin
      word[`ACRS_RDY_BIT] = s_reg.prdy;
      word[`ACRS_OVR_BIT] = s_reg.povr;
      word[RES_W-1:0] = s_reg.pval;
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.nirq = 1'b0;
    s_next.pirq = 1'b0;
    idx = fix_rep ? seq_slot : map[2:0];
    store = 1'b0;
    hit = 1'b0;
    if (capture) begin
      s_next.rdata = word;
    end
    // Only bits that the answer showed as set are cleared, so an event that
    // lands between capture and completion of the read is kept.
    if (rd_take && avs_req_in.address == `ACRS_OFF_NMODE && s_reg.rdata[`ACRS_END_BIT]) begin
      s_next.nend = 1'b0;
    end
    if (rd_take && avs_req_in.address == `ACRS_OFF_PMODE && s_reg.rdata[`ACRS_END_BIT]) begin
      s_next.pend = 1'b0;
    end
    // Any read of a result address hands it over, whatever its byte enables.
    for (int i = 0; i < `ACRS_SLOTS; i++) begin
      if (rd_take && is_slot(avs_req_in.address, i)) begin
        if (s_reg.rdata[`ACRS_RDY_BIT]) begin
          s_next.rdy[i] = 1'b0;
        end
        if (s_reg.rdata[`ACRS_OVR_BIT]) begin
          s_next.ovr[i] = 1'b0;
        end
      end
    end
    if (rd_take && avs_req_in.address == `ACRS_OFF_PRES) begin
      if (s_reg.rdata[`ACRS_RDY_BIT]) begin
        s_next.prdy = 1'b0;
      end
      if (s_reg.rdata[`ACRS_OVR_BIT]) begin
        s_next.povr = 1'b0;
      end
    end
    if (take && avs_req_in.write && avs_req_in.address == `ACRS_OFF_NMODE &&
        avs_req_in.byteenable[0]) begin
      s_next.repeat_on = avs_req_in.writedata[`ACRS_REPEAT_BIT];
      s_next.scan_on = avs_req_in.writedata[`ACRS_SCAN_BIT];
      s_next.itm = avs_req_in.writedata[`ACRS_ITM_LSB +: 2];
    end
    if (conv_evt_in.start_normal) begin
      s_next.nbusy = 1'b1;
    end
    if (conv_evt_in.start_prio) begin
      s_next.pbusy = 1'b1;
    end
    if (conv_evt_in.done && conv_evt_in.prio) begin
      s_next.pval = conv_evt_in.data[RES_W-1:0];
      s_next.povr = s_reg.prdy || s_reg.povr;
      s_next.prdy = 1'b1;
      s_next.pend = 1'b1;
      s_next.pirq = 1'b1;
      s_next.pbusy = 1'b0;
    end
    if (conv_evt_in.done && !conv_evt_in.prio) begin
      store = fix_rep || map[3];
      hit = fix_rep ? seq_wrap : (!s_reg.scan_on || conv_evt_in.scan_end);
      if (store) begin
        s_next.val[idx] = conv_evt_in.data[RES_W-1:0];
        // An unread result being replaced is flagged as overrun.
        s_next.ovr[idx] = s_reg.rdy[idx] || s_reg.ovr[idx];
        s_next.rdy[idx] = 1'b1;
      end
      if (hit) begin
        s_next.nend = 1'b1;
        s_next.nirq = 1'b1;
      end
      // Clearing the repeat bit lets the running conversion end the mode.
      if (!s_reg.repeat_on && (!s_reg.scan_on || conv_evt_in.scan_end)) begin
        s_next.nbusy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign avs_readdata_out = s_reg.rdata;
  assign normal_done_irq_out = s_reg.nirq;
  assign priority_done_irq_out = s_reg.pirq;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  irq_with_end_a: assert property (@(posedge clk_in) disable iff (srst_in)
    normal_done_irq_out |-> s_reg.nend ##1
      (!normal_done_irq_out || $past(conv_evt_in.done && !conv_evt_in.prio)))
    else $error("normal interrupt without end flag");

  fixed_single_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (conv_evt_in.done && !conv_evt_in.prio && !s_reg.repeat_on && !s_reg.scan_on &&
     !conv_evt_in.start_normal) |=> normal_done_irq_out && s_reg.nend && !s_reg.nbusy)
    else $error("fixed single completion wrong");

  repeat_busy_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (conv_evt_in.done && !conv_evt_in.prio && s_reg.repeat_on && s_reg.nbusy) |=> s_reg.nbusy)
    else $error("busy dropped in repeat mode");

  one_slot_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (seq_step && s_reg.itm == `ACRS_ITM_ONE) |=> normal_done_irq_out && s_reg.rdy[0])
    else $error("per-conversion repeat not stored in slot 0");

  four_group_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (seq_step && s_reg.itm == `ACRS_ITM_FOUR && !seq_clear)
      |=> normal_done_irq_out == ($past(seq_slot) == `ACRS_LAST_FOUR))
    else $error("four-conversion interval wrong");

  eight_group_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (seq_step && s_reg.itm == `ACRS_ITM_EIGHT && seq_slot == `ACRS_LAST_EIGHT)
      |=> normal_done_irq_out && seq_slot == 3'h0)
    else $error("eight-conversion interval wrong");

  reserved_itm_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (seq_step && s_reg.itm == `ACRS_ITM_RSVD) |=> !normal_done_irq_out)
    else $error("reserved interval raised interrupt");

  scan_mid_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (conv_evt_in.done && !conv_evt_in.prio && s_reg.scan_on && !conv_evt_in.scan_end)
      |=> !normal_done_irq_out)
    else $error("scan interrupt before pass end");

  prio_done_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (conv_evt_in.done && conv_evt_in.prio && !conv_evt_in.start_prio)
      |=> priority_done_irq_out && s_reg.pend && !s_reg.pbusy && s_reg.prdy)
    else $error("priority completion wrong");

  end_clear_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (rd_take && avs_req_in.address == `ACRS_OFF_NMODE && s_reg.rdata[`ACRS_END_BIT] &&
     !(conv_evt_in.done && hit))
      |=> !s_reg.nend)
    else $error("end flag not cleared by read");

  map_high_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (conv_evt_in.done && !conv_evt_in.prio && !fix_rep && conv_evt_in.channel == 4'hA)
      |=> s_reg.rdy[2] && s_reg.val[2] == $past(conv_evt_in.data[RES_W-1:0]))
    else $error("input 10 not stored in slot 2");

  start_busy_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (conv_evt_in.start_normal && !conv_evt_in.done) |=> s_reg.nbusy)
    else $error("busy not set at start");

  busy_prio_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (conv_evt_in.start_prio && !conv_evt_in.done)
      |=> s_reg.pbusy)
    else $error("priority busy not set at start");

  prio_irq_end_a: assert property (@(posedge clk_in) disable iff (srst_in)
    priority_done_irq_out
      |-> s_reg.pend)
    else $error("priority interrupt without end flag");

  scan_pass_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (conv_evt_in.done && !conv_evt_in.prio && s_reg.repeat_on && s_reg.scan_on &&
     conv_evt_in.scan_end) |=> normal_done_irq_out && s_reg.nend)
    else $error("scan pass end gave no interrupt");

  scan_single_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (conv_evt_in.done && !conv_evt_in.prio && !s_reg.repeat_on && s_reg.scan_on &&
     conv_evt_in.scan_end) |=> normal_done_irq_out && !s_reg.nbusy)
    else $error("scan single end wrong");

  seq_fill_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (seq_step && s_reg.itm == `ACRS_ITM_FOUR && !seq_clear && seq_slot != `ACRS_LAST_FOUR)
      |=> s_reg.rdy[$past(seq_slot)] && seq_slot == 3'($past(seq_slot) + 3'h1))
    else $error("four-slot sequence did not advance");

  prio_apart_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (conv_evt_in.done && conv_evt_in.prio && !rd_take)
      |=> $stable(s_reg.rdy) && $stable(s_reg.val))
    else $error("priority result touched normal slots");

  overrun_mark_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (store && s_reg.rdy[idx])
      |=> s_reg.ovr[$past(idx)] && s_reg.rdy[$past(idx)])
    else $error("overwritten result not flagged overrun");

  pend_clear_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (rd_take && avs_req_in.address == `ACRS_OFF_PMODE && s_reg.rdata[`ACRS_END_BIT] &&
     !(conv_evt_in.done && conv_evt_in.prio)) |=> !s_reg.pend)
    else $error("priority end flag not cleared by read");

endmodule : acrs_top
